// file: design/lcc_consts.svh
// Purpose: shared constants of the linear charger control block
// Assumes: included by bare name from every design file that needs it
// Notes:   definitions only
`ifndef LCC_CONSTS_SVH
`define LCC_CONSTS_SVH

// ****************************************
// host commands
// ****************************************
`define LCC_CMD_WRITE         8'h01
`define LCC_CMD_READ          8'h51

// ****************************************
// register layout and reset
// ****************************************
`define LCC_REG_RESET         8'h00
`define LCC_BIT_SUPPLY_OK     7
`define LCC_BIT_STOPPED       6
`define LCC_BIT_OVERTEMP      5
`define LCC_BIT_DIVIDER       4
`define LCC_CODE_DISABLE      4'hF

// ****************************************
// current arithmetic, tenths of a milliamp
// ****************************************
`define LCC_TRICKLE_FIXED_X10 14'h0053
`define LCC_CC_DIVISOR        14'h000C
`define LCC_TENTHS            14'h000A

// ****************************************
// serial byte framing, counted in clock-line rises
// ****************************************
`define LCC_ACK_SLOT          4'h8
`define LCC_BYTE_END          4'h9

`endif

// file: design/lcc_pkg.sv
// Purpose: types and helpers of the linear charger control block
// Assumes: nothing
// Notes:   constants live in lcc_consts.svh
package lcc_pkg;

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [2:0] {
      LCC_IDLE    = 3'h0,
      LCC_TRICKLE = 3'h1,
      LCC_CC      = 3'h3,
      LCC_CV      = 3'h2,
      LCC_FULL    = 3'h6
   } lcc_stage_e;

   typedef enum logic [2:0] {
      LCC_SLEEP  = 3'h0,
      LCC_CMD    = 3'h1,
      LCC_RX     = 3'h3,
      LCC_TX     = 3'h2,
      LCC_IGNORE = 3'h6
   } lcc_link_e;

   typedef struct packed {
      logic vcc_above_bat;
      logic vbat_ge_2v5;
      logic vbat_ge_3v0;
      logic vbat_ge_4v2;
      logic vbat_le_4v0;
      logic ibat_below_cc12;
      logic temp_above_110;
      logic temp_below_85;
      logic vcc_above_3v3;
   } lcc_sense_s;

   typedef struct packed {
      logic       input_supply_ok;
      logic       charge_stopped;
      logic       overtemp_flag;
      logic       battery_divider_enable;
      logic [3:0] charge_current_select;
   } lcc_reg_s;

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [9:0] lcc_cc_ma(input logic [3:0] code);
      case (code)
         4'h0, 4'h1, 4'h2: lcc_cc_ma = 10'h064;
         4'h3:             lcc_cc_ma = 10'h096;
         4'h4:             lcc_cc_ma = 10'h0C8;
         4'h5:             lcc_cc_ma = 10'h0FA;
         4'h6:             lcc_cc_ma = 10'h12C;
         4'h7:             lcc_cc_ma = 10'h15E;
         4'h8:             lcc_cc_ma = 10'h190;
         4'h9:             lcc_cc_ma = 10'h1F4;
         4'hA:             lcc_cc_ma = 10'h258;
         4'hB:             lcc_cc_ma = 10'h2BC;
         4'hC:             lcc_cc_ma = 10'h320;
         4'hD:             lcc_cc_ma = 10'h384;
         4'hE:             lcc_cc_ma = 10'h3E8;
         default:          lcc_cc_ma = 10'h000;
      endcase
   endfunction : lcc_cc_ma

   function automatic logic lcc_charging(input lcc_stage_e st);
      lcc_charging = (st == LCC_TRICKLE) || (st == LCC_CC) || (st == LCC_CV);
   endfunction : lcc_charging

endpackage : lcc_pkg

// file: design/lcc_i2c_slave.sv
// Purpose: two-byte serial command port of the charger register
// Assumes: clock and data lines already synchronous to clk
// Notes:   first byte is the command, second is data in or out
`timescale 1ns/100ps
`include "lcc_consts.svh"

module lcc_i2c_slave
   import lcc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   input  wire logic [7:0] rd_data,
   output logic            sda_oe,
   output logic            wr_stb,
   output logic [7:0]      wr_data,
   output logic            awake
);

   // ****************************************
   // line events
   // ****************************************
   logic       scl_q_r;
   logic       sda_q_r;
   lcc_link_e  st_r;
   logic [3:0] cnt_r;
   logic [7:0] sh_r;
   logic [7:0] tx_r;
   logic       oe_r;
   logic       stb_r;
   logic       awake_r;

   wire scl_rise = scl_i & ~scl_q_r;
   wire scl_fall = ~scl_i & scl_q_r;
   wire start_c  = scl_i & scl_q_r & sda_q_r & ~sda_i;
   wire stop_c   = scl_i & scl_q_r & ~sda_q_r & sda_i;
   wire is_wr    = (sh_r == `LCC_CMD_WRITE);
   wire is_rd    = (sh_r == `LCC_CMD_READ);
   wire at_ack   = scl_fall && (cnt_r == `LCC_ACK_SLOT);
   wire at_end   = scl_fall && (cnt_r == `LCC_BYTE_END);
   wire tx_bit   = scl_fall && (st_r == LCC_TX) && (cnt_r != 4'h0) && (cnt_r < `LCC_ACK_SLOT);

   assign sda_oe  = oe_r;
   assign wr_stb  = stb_r;
   assign wr_data = sh_r;
   assign awake   = awake_r;

   // ****************************************
   // byte engine
   // ****************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_q_r <= 1'b1;
         sda_q_r <= 1'b1;
         st_r    <= LCC_SLEEP;
         cnt_r   <= 4'h0;
         sh_r    <= 8'h00;
         tx_r    <= 8'h00;
         oe_r    <= 1'b0;
         stb_r   <= 1'b0;
         awake_r <= 1'b0;
      end else begin
         scl_q_r <= scl_i;
         sda_q_r <= sda_i;
         stb_r   <= 1'b0;
         awake_r <= (st_r != LCC_SLEEP);
         if (start_c) begin
            st_r  <= LCC_CMD;
            cnt_r <= 4'h0;
            oe_r  <= 1'b0;
         end else if (stop_c) begin
            st_r  <= LCC_SLEEP;
            oe_r  <= 1'b0;
         end else if (st_r != LCC_SLEEP) begin
            if (scl_rise && (cnt_r < `LCC_BYTE_END)) begin
               cnt_r <= cnt_r + 4'h1;
               if (cnt_r < `LCC_ACK_SLOT) begin
                  sh_r <= {sh_r[6:0], sda_i};
               end
            end
            if (at_ack) begin
               case (st_r)
                  LCC_CMD:  oe_r <= is_wr | is_rd;
                  LCC_RX: begin
                     oe_r  <= 1'b1;
                     stb_r <= 1'b1;
                  end
                  default:  oe_r <= 1'b0;
               endcase
            end else if (at_end) begin
               cnt_r <= 4'h0;
               if (st_r == LCC_CMD && is_wr) begin
                  st_r <= LCC_RX;
                  oe_r <= 1'b0;
               end else if (st_r == LCC_CMD && is_rd) begin
                  st_r <= LCC_TX;
                  tx_r <= rd_data;
                  oe_r <= ~rd_data[7];
               end else begin
                  st_r <= LCC_IGNORE;
                  oe_r <= 1'b0;
               end
            end else if (tx_bit) begin
               oe_r <= ~tx_r[6];
               tx_r <= {tx_r[6:0], 1'b0};
            end
         end
      end
   end

   // ****************************************
   // checks
   // ****************************************
   sequence s_data_ack;
      scl_fall && cnt_r == `LCC_ACK_SLOT && st_r == LCC_RX;
   endsequence

   property p_data_ack;
      @(posedge clk) disable iff (!rst_n) s_data_ack |=> oe_r && stb_r;
   endproperty
   a_data_ack: assert property (p_data_ack) else $error("data byte not acked or stored");

   property p_bad_cmd;
      @(posedge clk) disable iff (!rst_n)
         (at_ack && st_r == LCC_CMD && !is_wr && !is_rd && !start_c && !stop_c) |=> !oe_r;
   endproperty
   a_bad_cmd: assert property (p_bad_cmd) else $error("unknown command acked");

   property p_sleep;
      @(posedge clk) disable iff (!rst_n) stop_c |=> st_r == LCC_SLEEP ##1 !awake_r;
   endproperty
   a_sleep: assert property (p_sleep) else $error("no sleep after stop");

endmodule : lcc_i2c_slave

// file: design/lcc_top.sv
// Purpose: linear charger stage control, status flags and command port
// Assumes: comparator inputs synchronous to REF_CLK
// Notes:   analogue regulation lives outside; this block picks stage and current
`timescale 1ns/100ps
`include "lcc_consts.svh"

module lcc_top
   import lcc_pkg::*;
(
   input  wire logic        REF_CLK,
   input  wire logic        ARST_N,
   input  wire lcc_sense_s  SENSE,
   input  wire logic        SCL,
   input  wire logic        SDA_I,
   output logic             SDA_O,
   output logic             SDA_OE,
   output logic             I2C_AWAKE,
   output lcc_stage_e       CHARGE_STAGE,
   output logic [13:0]      CHARGE_CURRENT_X10,
   output logic             INPUT_SUPPLY_OK,
   output logic             CHARGE_STOPPED,
   output logic             OVERTEMP_FLAG,
   output logic             BATTERY_DIVIDER_ENABLE,
   output logic [3:0]       CHARGE_CURRENT_SELECT,
   output logic             SUPPLY_LEVEL_INDICATOR_O,
   output logic             SUPPLY_LEVEL_INDICATOR_OE
);

   // ****************************************
   // declarations
   // ****************************************
   lcc_stage_e  stage_r;
   lcc_stage_e  stage_nxt;
   lcc_reg_s    reg_r;
   logic [13:0] cur_r;
   logic [13:0] cur_nxt;
   logic        sli_oe_r;
   logic        zero_r;
   logic        wr_stb;
   logic [7:0]  wr_data;

   // ****************************************
   // decode
   // ****************************************
   wire        disabled = (reg_r.charge_current_select == `LCC_CODE_DISABLE);
   wire        go       = reg_r.input_supply_ok & ~disabled;
   wire [13:0] cc_x10   = 14'(lcc_cc_ma(reg_r.charge_current_select) * `LCC_TENTHS);
   // integer division truncates, so 800mA gives 66.6mA as 666 tenths
   wire [13:0] cc12_x10 = cc_x10 / `LCC_CC_DIVISOR;
   wire [7:0]  rd_data  = reg_r;

   // ****************************************
   // stage sequence
   // ****************************************
   always_comb begin
      stage_nxt = stage_r;
      if (!go) begin
         stage_nxt = LCC_IDLE;
      end else begin
         case (stage_r)
            LCC_IDLE:    stage_nxt = LCC_TRICKLE;
            LCC_TRICKLE: if (SENSE.vbat_ge_3v0) begin
               stage_nxt = LCC_CC;
            end
            LCC_CC:      if (SENSE.vbat_ge_4v2) begin
               stage_nxt = LCC_CV;
            end
            LCC_CV:      if (SENSE.ibat_below_cc12) begin
               stage_nxt = LCC_FULL;
            end
            LCC_FULL:    if (SENSE.vbat_le_4v0) begin
               stage_nxt = LCC_TRICKLE;
            end
            default:     stage_nxt = LCC_IDLE;
         endcase
      end
   end

   always_comb begin
      case (stage_nxt)
         LCC_TRICKLE: cur_nxt = SENSE.vbat_ge_2v5 ? cc12_x10 : `LCC_TRICKLE_FIXED_X10;
         LCC_CC:      cur_nxt = cc_x10;
         LCC_CV:      cur_nxt = cc_x10;
         default:     cur_nxt = 14'h0000;
      endcase
   end

   // ****************************************
   // state and register
   // ****************************************
   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         stage_r <= LCC_IDLE;
         cur_r   <= 14'h0000;
      end else begin
         stage_r <= stage_nxt;
         cur_r   <= cur_nxt;
      end
   end

   // status bits track hardware; writes reach only the low five bits
   always_ff @(posedge REF_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         reg_r    <= `LCC_REG_RESET;
         sli_oe_r <= 1'b0;
         zero_r   <= 1'b0;
      end else begin
         reg_r.input_supply_ok <= SENSE.vcc_above_bat;
         reg_r.charge_stopped  <= ~lcc_charging(stage_nxt);
         if (SENSE.temp_above_110) begin
            reg_r.overtemp_flag <= 1'b1;
         end else if (SENSE.temp_below_85) begin
            reg_r.overtemp_flag <= 1'b0;
         end
         if (wr_stb) begin
            reg_r.battery_divider_enable <= wr_data[`LCC_BIT_DIVIDER];
            reg_r.charge_current_select  <= wr_data[3:0];
         end
         sli_oe_r <= SENSE.vcc_above_3v3;
         zero_r   <= 1'b0;
      end
   end

   lcc_i2c_slave u_port (
      .clk     (REF_CLK),
      .rst_n   (ARST_N),
      .scl_i   (SCL),
      .sda_i   (SDA_I),
      .rd_data (rd_data),
      .sda_oe  (SDA_OE),
      .wr_stb  (wr_stb),
      .wr_data (wr_data),
      .awake   (I2C_AWAKE)
   );

   assign SDA_O                     = zero_r;
   assign CHARGE_STAGE              = stage_r;
   assign CHARGE_CURRENT_X10        = cur_r;
   assign INPUT_SUPPLY_OK           = reg_r.input_supply_ok;
   assign CHARGE_STOPPED            = reg_r.charge_stopped;
   assign OVERTEMP_FLAG             = reg_r.overtemp_flag;
   assign BATTERY_DIVIDER_ENABLE    = reg_r.battery_divider_enable;
   assign CHARGE_CURRENT_SELECT     = reg_r.charge_current_select;
   assign SUPPLY_LEVEL_INDICATOR_O  = zero_r;
   assign SUPPLY_LEVEL_INDICATOR_OE = sli_oe_r;

   // ****************************************
   // checks
   // ****************************************
   property p_supply;
      @(posedge REF_CLK) disable iff (!ARST_N) SENSE.vcc_above_bat |=> INPUT_SUPPLY_OK;
   endproperty
   a_supply: assert property (p_supply) else $error("supply ok not set");

   property p_no_charge;
      @(posedge REF_CLK) disable iff (!ARST_N) !INPUT_SUPPLY_OK |=> stage_r == LCC_IDLE && CHARGE_STOPPED;
   endproperty
   a_no_charge: assert property (p_no_charge) else $error("charging with abnormal input");

   property p_stopped;
      @(posedge REF_CLK) disable iff (!ARST_N) lcc_charging(stage_r) |-> !CHARGE_STOPPED;
   endproperty
   a_stopped: assert property (p_stopped) else $error("stopped flag set while charging");

   property p_first_trickle;
      @(posedge REF_CLK) disable iff (!ARST_N)
         ($past(stage_r) == LCC_IDLE && stage_r != LCC_IDLE) |-> stage_r == LCC_TRICKLE;
   endproperty
   a_first_trickle: assert property (p_first_trickle) else $error("cycle did not start in trickle");

   property p_trickle_low;
      @(posedge REF_CLK) disable iff (!ARST_N)
         (stage_nxt == LCC_TRICKLE && !SENSE.vbat_ge_2v5) |=> CHARGE_CURRENT_X10 == 14'h0053;
   endproperty
   a_trickle_low: assert property (p_trickle_low) else $error("trickle fixed current wrong");

   property p_to_cc;
      @(posedge REF_CLK) disable iff (!ARST_N)
         (stage_r == LCC_TRICKLE && go && SENSE.vbat_ge_3v0) |=> stage_r == LCC_CC;
   endproperty
   a_to_cc: assert property (p_to_cc) else $error("no constant current stage");

   property p_disable;
      @(posedge REF_CLK) disable iff (!ARST_N) disabled |=> stage_r == LCC_IDLE ##0 cur_r == 14'h0000;
   endproperty
   a_disable: assert property (p_disable) else $error("code 1111 did not disable");

   property p_to_cv;
      @(posedge REF_CLK) disable iff (!ARST_N) (stage_r == LCC_CC && go && SENSE.vbat_ge_4v2) |=> stage_r == LCC_CV;
   endproperty
   a_to_cv: assert property (p_to_cv) else $error("no constant voltage stage");

   sequence s_cv_done;
      stage_r == LCC_CV && go && SENSE.ibat_below_cc12;
   endsequence

   property p_full;
      @(posedge REF_CLK) disable iff (!ARST_N) s_cv_done |=> stage_r == LCC_FULL && CHARGE_STOPPED;
   endproperty
   a_full: assert property (p_full) else $error("charge did not end");

   property p_recharge;
      @(posedge REF_CLK) disable iff (!ARST_N) (stage_r == LCC_FULL && go && SENSE.vbat_le_4v0) |=> !CHARGE_STOPPED;
   endproperty
   a_recharge: assert property (p_recharge) else $error("no recharge");

   property p_divider;
      @(posedge REF_CLK) disable iff (!ARST_N) wr_stb |=> BATTERY_DIVIDER_ENABLE == $past(wr_data[4]);
   endproperty
   a_divider: assert property (p_divider) else $error("divider enable not written");

   property p_overtemp;
      @(posedge REF_CLK) disable iff (!ARST_N)
         (SENSE.temp_above_110 |=> OVERTEMP_FLAG) and
         ((SENSE.temp_below_85 && !SENSE.temp_above_110) |=> !OVERTEMP_FLAG);
   endproperty
   a_overtemp: assert property (p_overtemp) else $error("overtemp hysteresis broken");

   property p_indicator;
      @(posedge REF_CLK) disable iff (!ARST_N)
         SENSE.vcc_above_3v3 |=> SUPPLY_LEVEL_INDICATOR_OE && !SUPPLY_LEVEL_INDICATOR_O;
   endproperty
   a_indicator: assert property (p_indicator) else $error("indicator not driven low");

   property p_status_kept;
      @(posedge REF_CLK) disable iff (!ARST_N)
         (wr_stb && !SENSE.temp_above_110 && !SENSE.temp_below_85) |=> OVERTEMP_FLAG == $past(OVERTEMP_FLAG);
   endproperty
   a_status_kept: assert property (p_status_kept) else $error("write changed a status bit");

endmodule : lcc_top

// file: sim/lcc_host_model.sv
// Purpose: serial host model for the charger command port
// Assumes: open-drain data line with a pull-up
// Notes:   fixed slow bit timing, three clock cycles per line phase
`timescale 1ns/100ps

module lcc_host_model (
   input  wire logic clk,
   input  wire logic sda_oe,
   output logic      scl,
   output wire logic sda
);
   logic sda_drv = 1'b1;

   initial scl = 1'b1;
   // pull-up wins unless somebody pulls low
   assign sda = sda_drv & ~sda_oe;

   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask : tick

   task automatic start_cond;
      sda_drv = 1'b1;
      tick(1);
      scl = 1'b1;
      tick(3);
      sda_drv = 1'b0;
      tick(3);
      scl = 1'b0;
      tick(3);
   endtask : start_cond

   task automatic stop_cond;
      sda_drv = 1'b0;
      tick(1);
      scl = 1'b1;
      tick(3);
      sda_drv = 1'b1;
      tick(4);
   endtask : stop_cond

   // data only moves while the clock line is low
   task automatic xbit(input logic b, output logic r);
      sda_drv = b;
      tick(1);
      scl = 1'b1;
      tick(2);
      r = sda;
      tick(1);
      scl = 1'b0;
      tick(2);
   endtask : xbit

   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         xbit(tx[i], r);
         rx[i] = r;
      end
      xbit(1'b1, r);
      ack = ~r;
   endtask : xfer
endmodule : lcc_host_model

// file: sim/tb.sv
// Purpose: self-checking bench of the charger control block
// Assumes: host model on the serial port, comparators driven here
// Notes:   lfsr picks the upper four written bits (divider enable and three status bits) and the 3.3V comparator
`timescale 1ns/100ps
`include "lcc_consts.svh"

module tb
   import lcc_pkg::*;
;
   logic        ref_clk   = 1'b0;
   logic        arst_n    = 1'b0;
   lcc_sense_s  sense     = '0;
   wire         scl_w;
   wire         sda_w;
   logic        sda_o, sda_oe, awake, ok, stopped, ot, div, ind_o, ind_oe;
   lcc_stage_e  stage;
   logic [13:0] cur;
   logic [3:0]  sel;
   logic [15:0] rnd       = 16'h635B;
   int          err_count = 0;
   int          n_tests   = 0;
   logic [8:0]  walk_sense [9] = '{9'h110, 9'h190, 9'h1D0, 9'h1E0, 9'h1E8, 9'h1C0, 9'h1D0, 9'h1D0, 9'h0D0};
   lcc_stage_e  walk_stage [9] = '{LCC_TRICKLE, LCC_TRICKLE, LCC_CC, LCC_CV, LCC_FULL, LCC_FULL,
                                   LCC_TRICKLE, LCC_CC, LCC_IDLE};
   int          walk_wait  [9] = '{3, 3, 3, 3, 3, 3, 1, 3, 3};

   always #5 ref_clk = ~ref_clk;

   lcc_top DUT (
      .REF_CLK                   (ref_clk),
      .ARST_N                    (arst_n),
      .SENSE                     (sense),
      .SCL                       (scl_w),
      .SDA_I                     (sda_w),
      .SDA_O                     (sda_o),
      .SDA_OE                    (sda_oe),
      .I2C_AWAKE                 (awake),
      .CHARGE_STAGE              (stage),
      .CHARGE_CURRENT_X10        (cur),
      .INPUT_SUPPLY_OK           (ok),
      .CHARGE_STOPPED            (stopped),
      .OVERTEMP_FLAG             (ot),
      .BATTERY_DIVIDER_ENABLE    (div),
      .CHARGE_CURRENT_SELECT     (sel),
      .SUPPLY_LEVEL_INDICATOR_O  (ind_o),
      .SUPPLY_LEVEL_INDICATOR_OE (ind_oe)
   );

   lcc_host_model host (
      .clk    (ref_clk),
      .sda_oe (sda_oe),
      .scl    (scl_w),
      .sda    (sda_w)
   );

   // ********
   // helpers
   // ********
   function automatic logic [15:0] lfsr(input logic [15:0] x);
      lfsr = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction : lfsr

   function automatic logic [13:0] ma_of(input logic [3:0] c);
      if (c < 4'h3) ma_of = 14'h0064;
      else if (c < 4'h9) ma_of = 14'h0032 * c;
      else ma_of = 14'h0064 * c - 14'h0190;
   endfunction : ma_of

   function automatic logic [13:0] exp_cur(input lcc_stage_e st, input logic [3:0] c, input logic hi);
      case (st)
         LCC_TRICKLE: exp_cur = hi ? ma_of(c) * 14'h000A / 14'h000C : 14'h0053;
         LCC_CC, LCC_CV: exp_cur = ma_of(c) * 14'h000A;
         default: exp_cur = 14'h0000;
      endcase
   endfunction : exp_cur

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic xact(input logic [7:0] cmd, input logic [7:0] dat, input logic third,
                       output logic [7:0] rx, output logic [2:0] acks);
      logic [7:0] junk;
      host.start_cond();
      chk(awake, 1'b1);
      host.xfer(cmd, junk, acks[2]);
      host.xfer(dat, rx, acks[1]);
      acks[0] = 1'b0;
      if (third) host.xfer(8'h5A, junk, acks[0]);
      host.stop_cond();
      chk(awake, 1'b0);
   endtask : xact

   task automatic wrap_up;
      if (err_count == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : wrap_up

   // ********
   // main sequence
   // ********
   initial begin : main
      logic [7:0]  rx, wd;
      logic [2:0]  acks;
      logic [3:0]  code;
      lcc_stage_e  exp_st;
      repeat (5) @(negedge ref_clk);
      chk({ok, stopped, ot, div, sel, stage, cur, sda_oe, ind_oe}, 32'h0000_0000);
      arst_n = 1'b1;
      repeat (3) @(negedge ref_clk);
      chk({stopped, sda_o}, 2'b10);
      for (int i = 0; i < 16; i++) begin
         code = i[3:0];
         rnd  = lfsr(rnd);
         wd   = {rnd[7:4], code};
         xact(`LCC_CMD_WRITE, wd, 1'b0, rx, acks);
         chk(acks, 3'b110);
         chk({div, sel}, wd[4:0]);
         xact(`LCC_CMD_READ, 8'hFF, 1'b0, rx, acks);
         chk(acks, 3'b100);
         chk(rx, {3'b010, wd[4:0]});
         for (int s = 0; s < 9; s++) begin
            rnd    = lfsr(rnd);
            sense  = walk_sense[s] | {8'h00, rnd[0]};
            exp_st = (code == `LCC_CODE_DISABLE) ? LCC_IDLE : walk_stage[s];
            repeat (walk_wait[s]) @(negedge ref_clk);
            chk(stage, exp_st);
            chk(cur, exp_cur(exp_st, code, sense.vbat_ge_2v5));
            chk(stopped, !(exp_st inside {LCC_TRICKLE, LCC_CC, LCC_CV}));
            chk(ok, sense.vcc_above_bat);
            if (walk_wait[s] == 3) chk({ind_oe, ind_o}, {rnd[0], 1'b0});
         end
      end
      // third byte and unknown command must both be ignored
      xact(`LCC_CMD_WRITE, 8'h1C, 1'b1, rx, acks);
      chk(acks, 3'b110);
      xact(8'h33, 8'h05, 1'b0, rx, acks);
      chk(acks, 3'b000);
      chk({div, sel}, 5'h1C);
      // hysteresis: set, hold with both comparators quiet, clear
      for (int t = 0; t < 3; t++) begin
         sense = (t == 0) ? 9'h004 : (t == 1) ? 9'h001 : 9'h002;
         repeat (3) @(negedge ref_clk);
         chk(ot, t < 2);
      end
      sense = 9'h1D4;
      repeat (3) @(negedge ref_clk);
      arst_n = 1'b0;
      @(negedge ref_clk);
      chk({ok, stopped, ot, div, sel, stage, cur}, 32'h0000_0000);
      wrap_up();
   end

   // 16 codes at well under 1500 cycles each
   initial begin : watchdog
      repeat (60000) @(posedge ref_clk);
      err_count++;
      wrap_up();
   end
endmodule : tb
